// file: src/slpw_pkg.sv
/*
  Constants, types and register map of the sleep-state, wake and power LED block.
  Assumes a single 250 MHz clock and an APB master with 32-bit data.
*/
// Functional notes
// - S1 stops CPU, devices stay powered, wake returns S0
// - S4 unpowers all but standby wake logic
// - S5 unpowers all but standby wake logic, wakes only enabled sources
// - G3 without standby: nothing powered, no wake
// - Power switch wakes S1/S4/S5, RTC S1/S4
// - Keyboard, mouse, USB wake from S1 only
// - LAN wakes S1/S4, S5 when enabled
// - Card wake request S1/S4, S5 when enabled
// - Single LED on only in S0
// - Dual LED: green S0, yellow S1, else off
// - Message waiting blinks the lit colour
package slpw_pkg;

  // Clock and blink timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int BLINK_HALF_NS = 500_000_000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int BLINK_CNT_W = 27;

  // Register byte offsets.
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] WAKE_STAT_OFF = 12'h008;
  localparam logic [11:0] WAKE_MASK_OFF = 12'h00C;

  // Control register field positions.
  localparam int CTRL_TGT_LSB = 0;
  localparam int CTRL_ENTER_BIT = 2;
  localparam int CTRL_DUAL_BIT = 3;
  localparam int CTRL_MSG_BIT = 4;
  localparam int CTRL_LAN_S5_BIT = 5;
  localparam int CTRL_CARD_S5_BIT = 6;

  // Status register field positions.
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_CPU_BIT = 3;
  localparam int STATUS_DEV_BIT = 4;
  localparam int STATUS_STBY_BIT = 5;

  // Sleep targets written to the control register.
  localparam logic [1:0] TGT_S1 = 2'h1;
  localparam logic [1:0] TGT_S4 = 2'h2;
  localparam logic [1:0] TGT_S5 = 2'h3;

  // Wake sources and the sets allowed per state.
  localparam int WAKE_N = 6;
  localparam int WAKE_LAN_BIT = 4;
  localparam int WAKE_CARD_BIT = 5;
  localparam logic [5:0] WAKE_ALLOW_S1 = 6'h3F;
  localparam logic [5:0] WAKE_ALLOW_S4 = 6'h33;
  localparam logic [5:0] WAKE_ALLOW_S5 = 6'h01;

  // Reset values.
  localparam logic [5:0] WAKE_MASK_RST = 6'h00;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {ST_G3, ST_S0, ST_S1, ST_S4, ST_S5} slpw_state_t;

  typedef struct packed {
    logic card_wake_request;
    logic lan;
    logic usb;
    logic kbd_mouse;
    logic rtc_alarm;
    logic power_switch;
  } slpw_wake_t;

  typedef struct packed {
    logic cpu_run;
    logic dev_pwr_en;
    logic wake_logic_en;
  } slpw_pwr_t;

  typedef struct packed {
    logic yellow;
    logic green;
  } slpw_led_t;

endpackage : slpw_pkg

// file: src/slpw_top.sv
/*
  Sleep-state sequencer with wake qualification, power LED driver and APB registers.
  Assumes wake inputs and standby_ok are synchronous to pclk and that pclk runs
  from the standby domain whenever standby power is present.
*/
`timescale 1ns/1ps

module slpw_top #(
  parameter int BLINK_HALF = slpw_pkg::BLINK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slpw_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby_ok,
  input wire slpw_pkg::slpw_wake_t wake_src,
  output slpw_pkg::slpw_pwr_t pwr,
  output slpw_pkg::slpw_led_t led,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  slpw_pkg::slpw_state_t state_reg;
  slpw_pkg::slpw_state_t state_next;
  slpw_pkg::slpw_pwr_t pwr_reg;
  slpw_pkg::slpw_led_t led_reg;
  logic [1:0] target_reg;
  logic dual_led_reg;
  logic message_waiting_source_reg;
  logic lan_s5_en_reg;
  logic card_s5_en_reg;
  logic [5:0] wake_stat_reg;
  logic [5:0] wake_mask_reg;
  logic [31:0] prdata_reg;
  logic [slpw_pkg::BLINK_CNT_W-1:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic [5:0] allow;
  logic [5:0] accepted;
  logic wake_hit;
  logic apb_wr;
  logic addr_hit;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic enter;
  logic lit;
  logic [31:0] rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave answers with no wait state.

  // Writes land in the access phase; unmapped offsets answer with an error.
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign addr_hit = (paddr == slpw_pkg::CTRL_OFF) || (paddr == slpw_pkg::STATUS_OFF) ||
                    (paddr == slpw_pkg::WAKE_STAT_OFF) || (paddr == slpw_pkg::WAKE_MASK_OFF);
  assign pslverr = psel && penable && !addr_hit;
  assign wr_ctrl = apb_wr && (paddr == slpw_pkg::CTRL_OFF);
  assign wr_stat = apb_wr && (paddr == slpw_pkg::WAKE_STAT_OFF);
  assign wr_mask = apb_wr && (paddr == slpw_pkg::WAKE_MASK_OFF);
  assign enter = wr_ctrl && pwdata[slpw_pkg::CTRL_ENTER_BIT];
  assign prdata = prdata_reg;

  // Read data mux; reserved bits read as zero.
  always_comb begin
    rd_data = '0;
    case (paddr)
      slpw_pkg::CTRL_OFF: begin
        rd_data[slpw_pkg::CTRL_TGT_LSB +: 2] = target_reg;
        rd_data[slpw_pkg::CTRL_DUAL_BIT] = dual_led_reg;
        rd_data[slpw_pkg::CTRL_MSG_BIT] = message_waiting_source_reg;
        rd_data[slpw_pkg::CTRL_LAN_S5_BIT] = lan_s5_en_reg;
        rd_data[slpw_pkg::CTRL_CARD_S5_BIT] = card_s5_en_reg;
      end
      slpw_pkg::STATUS_OFF: begin
        rd_data[slpw_pkg::STATUS_STATE_LSB +: 3] = state_reg;
        rd_data[slpw_pkg::STATUS_CPU_BIT] = pwr_reg.cpu_run;
        rd_data[slpw_pkg::STATUS_DEV_BIT] = pwr_reg.dev_pwr_en;
        rd_data[slpw_pkg::STATUS_STBY_BIT] = standby_ok;
      end
      slpw_pkg::WAKE_STAT_OFF: rd_data[5:0] = wake_stat_reg;
      slpw_pkg::WAKE_MASK_OFF: rd_data[5:0] = wake_mask_reg;
      default: rd_data = '0;
    endcase
  end

  // Read data is captured in the setup phase and held through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= slpw_pkg::PRDATA_RST;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_data;
    end
  end

  // Control register; the enter bit is an action and is not stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_reg <= 2'h0;
      dual_led_reg <= 1'b0;
      message_waiting_source_reg <= 1'b0;
      lan_s5_en_reg <= 1'b0;
      card_s5_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      target_reg <= pwdata[slpw_pkg::CTRL_TGT_LSB +: 2];
      dual_led_reg <= pwdata[slpw_pkg::CTRL_DUAL_BIT];
      message_waiting_source_reg <= pwdata[slpw_pkg::CTRL_MSG_BIT];
      lan_s5_en_reg <= pwdata[slpw_pkg::CTRL_LAN_S5_BIT];
      card_s5_en_reg <= pwdata[slpw_pkg::CTRL_CARD_S5_BIT];
    end
  end

  // Interrupt mask register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_mask_reg <= slpw_pkg::WAKE_MASK_RST;
    end else if (wr_mask) begin
      wake_mask_reg <= pwdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualification.

  // Sources allowed per state; S5 adds LAN and card only when enabled.
  always_comb begin
    allow = '0;
    case (state_reg)
      slpw_pkg::ST_S1: allow = slpw_pkg::WAKE_ALLOW_S1;
      slpw_pkg::ST_S4: allow = slpw_pkg::WAKE_ALLOW_S4;
      slpw_pkg::ST_S5: begin
        allow = slpw_pkg::WAKE_ALLOW_S5;
        allow[slpw_pkg::WAKE_LAN_BIT] = lan_s5_en_reg;
        allow[slpw_pkg::WAKE_CARD_BIT] = card_s5_en_reg;
      end
      default: allow = '0;
    endcase
  end

  // Without standby power nothing is accepted.
  assign accepted = standby_ok ? (wake_src & allow) : '0;
  assign wake_hit = |accepted;

  // Sticky wake flags; a new event wins over a write-one-to-clear.
  for (genvar gi = 0; gi < slpw_pkg::WAKE_N; gi++) begin : g_stat
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wake_stat_reg[gi] <= 1'b0;
      end else if (accepted[gi]) begin
        wake_stat_reg[gi] <= 1'b1;
      end else if (wr_stat && pwdata[gi]) begin
        wake_stat_reg[gi] <= 1'b0;
      end
    end
  end

  // Level interrupt while any unmasked flag is set.
  assign irq = |(wake_stat_reg & wake_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Sleep-state sequencer.

  // Loss of standby forces G3; software enters sleep only from S0.
  always_comb begin
    state_next = state_reg;
    if (!standby_ok) begin
      state_next = slpw_pkg::ST_G3;
    end else begin
      case (state_reg)
        slpw_pkg::ST_G3: state_next = slpw_pkg::ST_S5;
        slpw_pkg::ST_S0: begin
          if (enter) begin
            case (pwdata[slpw_pkg::CTRL_TGT_LSB +: 2])
              slpw_pkg::TGT_S1: state_next = slpw_pkg::ST_S1;
              slpw_pkg::TGT_S4: state_next = slpw_pkg::ST_S4;
              slpw_pkg::TGT_S5: state_next = slpw_pkg::ST_S5;
              default: state_next = slpw_pkg::ST_S0;
            endcase
          end
        end
        slpw_pkg::ST_S1, slpw_pkg::ST_S4, slpw_pkg::ST_S5: begin
          if (wake_hit) begin
            state_next = slpw_pkg::ST_S0;
          end
        end
        default: state_next = slpw_pkg::ST_G3;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= slpw_pkg::ST_G3;
    end else begin
      state_reg <= state_next;
    end
  end

  // Rail and processor controls follow the state being entered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= '0;
    end else begin
      pwr_reg.cpu_run <= (state_next == slpw_pkg::ST_S0);
      pwr_reg.dev_pwr_en <= (state_next == slpw_pkg::ST_S0) ||
                            (state_next == slpw_pkg::ST_S1);
      pwr_reg.wake_logic_en <= (state_next != slpw_pkg::ST_G3);
    end
  end

  assign pwr = pwr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Power LED.

  // Half-period divider for the message-waiting blink.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= 1'b0;
    end else if (blink_cnt_reg == slpw_pkg::BLINK_CNT_W'(BLINK_HALF - 1)) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= !blink_phase_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
  end

  // A waiting message turns the steady colour into a blink.
  assign lit = message_waiting_source_reg ? blink_phase_reg : 1'b1;

  // Green doubles as the single-colour drive; yellow is used only in dual mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_reg <= '0;
    end else begin
      led_reg.green <= (state_reg == slpw_pkg::ST_S0) && lit;
      led_reg.yellow <= dual_led_reg && (state_reg == slpw_pkg::ST_S1) && lit;
    end
  end

  assign led = led_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s1_wake_seq;
    (state_reg == slpw_pkg::ST_S1) && standby_ok && wake_hit;
  endsequence

  sequence s0_resume_seq;
    (state_reg == slpw_pkg::ST_S0) && pwr.cpu_run && pwr.dev_pwr_en;
  endsequence

  a_s1_resume: assert property (s1_wake_seq |=> s0_resume_seq)
    else $error("S1 wake did not resume S0 with power.");

  a_s1_cpu_off: assert property ((state_reg == slpw_pkg::ST_S1) |->
    (!pwr.cpu_run && pwr.dev_pwr_en))
    else $error("S1 power controls wrong.");

  a_s4_wake_only: assert property ((state_reg == slpw_pkg::ST_S4) |->
    (!pwr.dev_pwr_en && !pwr.cpu_run && pwr.wake_logic_en))
    else $error("S4 power controls wrong.");

  a_s5_no_wake: assert property (((state_reg == slpw_pkg::ST_S5) && standby_ok &&
    ((wake_src & ~allow) == wake_src)) && !wake_hit |=> (state_reg == slpw_pkg::ST_S5))
    else $error("S5 left without an enabled wake.");

  a_g3_dead: assert property (!standby_ok |=>
    ((state_reg == slpw_pkg::ST_G3) && (pwr == '0) && (accepted == '0)))
    else $error("G3 left logic powered or accepted a wake.");

  a_switch_rtc: assert property (((state_reg == slpw_pkg::ST_S5) |-> !allow[1]) and
    (((state_reg != slpw_pkg::ST_S0) && (state_reg != slpw_pkg::ST_G3) && standby_ok &&
    wake_src.power_switch) |=> (state_reg == slpw_pkg::ST_S0)))
    else $error("Power switch or RTC wake qualified wrongly.");

  a_port_s1only: assert property ((state_reg != slpw_pkg::ST_S1) |-> (allow[3:2] == 2'h0))
    else $error("Keyboard, mouse or USB allowed outside S1.");

  a_lan_option: assert property ((state_reg == slpw_pkg::ST_S5) |->
    (allow[slpw_pkg::WAKE_LAN_BIT] == lan_s5_en_reg))
    else $error("LAN wake from S5 ignores its enable.");

  a_card_wake: assert property (((state_reg == slpw_pkg::ST_S4) && standby_ok &&
    wake_src.card_wake_request) |=> (state_reg == slpw_pkg::ST_S0))
    else $error("Card wake request ignored in S4.");

  a_single_led: assert property (((state_reg != slpw_pkg::ST_S0) && !dual_led_reg) |=>
    (led == '0))
    else $error("Single LED lit outside S0.");

  a_dual_led: assert property (((state_reg == slpw_pkg::ST_S1) && dual_led_reg &&
    !message_waiting_source_reg) |=> (led.yellow && !led.green))
    else $error("Dual LED not steady yellow in S1.");

  a_blink_led: assert property (((state_reg == slpw_pkg::ST_S0) && message_waiting_source_reg)
    |=> (led.green == $past(blink_phase_reg)))
    else $error("Message waiting blink not followed.");

  a_blink_rate: assert property ($changed(blink_phase_reg) |->
    ($past(blink_cnt_reg) == slpw_pkg::BLINK_CNT_W'(BLINK_HALF - 1)))
    else $error("Blink phase toggled off its period.");

endmodule : slpw_top

// file: testbench/slpw_wake_model.sv
/*
  Far-side model: wake sources and the operating system's request pulses.
  Assumes the bench raises req for one cycle and that aux_ok mirrors standby power.
*/
`timescale 1ns/1ps

module slpw_wake_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic aux_ok,
  input wire slpw_pkg::slpw_wake_t req,
  output slpw_pkg::slpw_wake_t wake_src
);
  // Registers requests; a card can only signal wake while its auxiliary rail is up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_src <= '0;
    end else begin
      wake_src <= slpw_pkg::slpw_wake_t'(req & {aux_ok, 5'h1F});
    end
  end
endmodule : slpw_wake_model

// file: testbench/sleep_state_wake_and_power_led_tb_top.sv
/*
  Self-checking bench for the sleep-state, wake and LED block.
  Assumes APB with zero or more wait states and a shortened blink half period.
*/
`timescale 1ns/1ps

module sleep_state_wake_and_power_led_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic standby_ok = 1'b1;
  slpw_pkg::slpw_wake_t req = '0;
  slpw_pkg::slpw_wake_t wake_src;
  slpw_pkg::slpw_pwr_t pwr;
  slpw_pkg::slpw_led_t led;
  logic irq;
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic err;
  logic [5:0] allow;
  logic [2:0] st;

  // Clock of 4 ns period.
  always #2 pclk = ~pclk;

  slpw_top #(.BLINK_HALF(4)) slpw_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby_ok(standby_ok), .wake_src(wake_src),
    .pwr(pwr), .led(led), .irq(irq));

  slpw_wake_model slpw_wake_model_i (.pclk(pclk), .presetn(presetn), .aux_ok(standby_ok),
    .req(req), .wake_src(wake_src));

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // Compares one value against its expectation.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the completing edge's register updates settle before callers look at outputs.
    @(posedge pclk);
  endtask : apb

  // Reads the status word and checks state code and rail enables.
  task automatic expect_state(input logic [2:0] s, input logic [2:0] p);
    apb(1'b0, 12'h004, 32'h0);
    chk("state", {29'h0, rd[2:0]}, {29'h0, s});
    chk("pwr", {29'h0, pwr}, {29'h0, p});
  endtask : expect_state

  // Raises the given wake sources for one cycle through the far-side model.
  task automatic pulse(input logic [5:0] b);
    @(posedge pclk);
    req <= slpw_pkg::slpw_wake_t'(b);
    @(posedge pclk);
    req <= '0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // Counts lit cycles of one LED colour over two blink periods.
  task automatic blink(input int bitn, input int exp);
    int hi;
    hi = 0;
    repeat (16) begin
      @(posedge pclk);
      hi += int'(led[bitn]);
    end
    chk("blink", hi, exp);
  endtask : blink

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog for a hung handshake or sequence.
  initial begin
    #80000;
    miscompares++;
    $display("CHECK FAILED watchdog expected done seen hang");
    close_out();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge pclk);
    chk("rst", {27'h0, pwr, led}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("status", rd, 32'h24);
    pulse(6'h01);
    expect_state(3'h1, 3'h7);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 6; s++) begin
        st = (m == 0) ? 3'h2 : (m == 1) ? 3'h3 : 3'h4;
        allow = (m == 0) ? 6'h3F : (m == 1) ? 6'h33 : (m == 2) ? 6'h01 : 6'h31;
        apb(1'b1, 12'h000, ((m == 3) ? 32'h60 : 32'h0) | 32'h4 | (st - 3'h1));
        expect_state(st, (m == 0) ? 3'h3 : 3'h1);
        pulse(6'h01 << s);
        expect_state(allow[s] ? 3'h1 : st, allow[s] ? 3'h7 : ((m == 0) ? 3'h3 : 3'h1));
        apb(1'b0, 12'h008, 32'h0);
        chk("wake_stat", rd, allow[s] ? (32'h1 << s) : 32'h0);
        if (!allow[s]) begin
          pulse(6'h01);
        end
        apb(1'b1, 12'h008, 32'h3F);
      end
    end
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", rd, 32'h63);
    chk("led single", {30'h0, led}, 32'h1);
    apb(1'b1, 12'h00C, 32'h2);
    apb(1'b1, 12'h000, 32'h6);
    pulse(6'h02);
    apb(1'b0, 12'h00C, 32'h0);
    chk("mask", rd, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h00C, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h00C, 32'h2);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h008, 32'h2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h000, 32'h08);
    expect_state(3'h1, 3'h7);
    chk("led green", {30'h0, led}, 32'h1);
    apb(1'b1, 12'h000, 32'h0D);
    expect_state(3'h2, 3'h3);
    chk("led yellow", {30'h0, led}, 32'h2);
    pulse(6'h01);
    apb(1'b1, 12'h000, 32'h05);
    expect_state(3'h2, 3'h3);
    chk("led sleep", {30'h0, led}, 32'h0);
    pulse(6'h01);
    apb(1'b1, 12'h000, 32'h0E);
    expect_state(3'h3, 3'h1);
    chk("led s4", {30'h0, led}, 32'h0);
    pulse(6'h01);
    apb(1'b1, 12'h000, 32'h10);
    blink(0, 8);
    apb(1'b1, 12'h000, 32'h1D);
    expect_state(3'h2, 3'h3);
    blink(1, 8);
    blink(0, 0);
    pulse(6'h01);
    apb(1'b1, 12'h004, 32'hFF);
    apb(1'b0, 12'h004, 32'h0);
    chk("status ro", rd, 32'h39);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    // Earlier power switch wakes left flags set; clear them so G3 starts clean.
    apb(1'b1, 12'h008, 32'h3F);
    @(posedge pclk);
    standby_ok <= 1'b0;
    pulse(6'h3F);
    expect_state(3'h0, 3'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("g3 wake", rd, 32'h0);
    standby_ok <= 1'b1;
    repeat (2) @(posedge pclk);
    expect_state(3'h4, 3'h1);
    close_out();
  end
endmodule : sleep_state_wake_and_power_led_tb_top
